// ===== src/port_c_pin_function_direction.sv
/*
 * Port C pin function and direction control: two retained 16-bit registers,
 * mode override and per-pin drive of sixteen shared general/address pins.
 * Assumes RST_N_I is the external power-on reset only; manual reset, watchdog
 * reset, standby and sleep arrive as separate level inputs from the chip.
 */
`default_nettype none

module port_c_pin_function_direction
   import portc_pkg::*;
(
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic [3:0] REG_ADDR_I,
   input wire logic [15:0] REG_WDATA_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   output logic [15:0] REG_RDATA_O,
   input wire logic MODE_SINGLE_CHIP_I,
   input wire logic MODE_ROM_INVALID_I,
   input wire logic MANUAL_RST_N_I,
   input wire logic WDT_RST_I,
   input wire logic STANDBY_I,
   input wire logic SLEEP_I,
   input wire logic [15:0] PORT_DATA_I,
   input wire logic [15:0] ADDR_LINE_I,
   input wire logic [15:0] PIN_I,
   output logic [15:0] PIN_O,
   output logic [15:0] PIN_OE_O,
   output logic [15:0] PIN_LEVEL_O,
   output logic [15:0] ADDR_SELECT_O
);

   reg_req_t req;
   logic [15:0] direction_ff;
   logic [15:0] function_ff;
   logic [15:0] rdata_ff;
   logic [15:0] nxt_rdata;
   logic [15:0] pin_o_ff;
   logic [15:0] pin_oe_ff;
   logic [15:0] addr_sel_ff;
   logic [15:0] nxt_pin_o;
   logic [15:0] nxt_pin_oe;
   logic [15:0] nxt_addr_sel;
   logic [15:0] pin_sync;
   logic [3:0] ctl_sync;
   logic manual_rst_n_sync;
   logic hold_active;
   logic [1:0] strap_wait_ff;
   logic [1:0] strap_sync;
   chip_mode_t mode_ff;
   logic single_chip;
   logic rom_invalid;
   pin_drive_t drive [PIN_COUNT];

   assign req.addr = REG_ADDR_I;
   assign req.wdata = REG_WDATA_I;
   assign req.wr = REG_WR_I;
   assign req.rd = REG_RD_I;

   // Pins and chip-level reset/low-power levels may come from outside the clock domain
   sync_two_stage #(
      .WIDTH(PIN_COUNT)
   ) u_pin_sync (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .async_i(PIN_I),
      .sync_o(pin_sync)
   );

   sync_two_stage #(
      .WIDTH(4)
   ) u_ctl_sync (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .async_i({~MANUAL_RST_N_I, WDT_RST_I, STANDBY_I, SLEEP_I}),
      .sync_o(ctl_sync)
   );

   // Straps are pins too, so they settle through two flops before use
   sync_two_stage #(
      .WIDTH(2)
   ) u_strap_sync (
      .clk_i(CLK_SYS_I),
      .rst_n_i(RST_N_I),
      .async_i({MODE_SINGLE_CHIP_I, MODE_ROM_INVALID_I}),
      .sync_o(strap_sync)
   );

   assign manual_rst_n_sync = ~ctl_sync[3];
   // Writes are frozen while the chip is held in a non-power-on reset or low power
   assign hold_active = ~manual_rst_n_sync | (|ctl_sync[2:0]);

   // Counts edges after power-on release until the strap synchroniser holds real levels
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         strap_wait_ff <= 2'd0;
      end else if (strap_wait_ff != STRAP_DONE) begin
         strap_wait_ff <= strap_wait_ff + 2'd1;
      end
   end

   // Mode pins are straps: caught once, on the third edge after power-on release
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mode_ff <= MODE_NORMAL;
      end else if (strap_wait_ff == STRAP_SETTLE) begin
         if (strap_sync[1]) begin
            mode_ff <= MODE_SINGLE;
         end else if (strap_sync[0]) begin
            mode_ff <= MODE_ROMINV;
         end else begin
            mode_ff <= MODE_NORMAL;
         end
      end
   end

   always_comb begin
      case (mode_ff)
         MODE_NORMAL: begin
            single_chip = 1'b0;
            rom_invalid = 1'b0;
         end
         MODE_SINGLE: begin
            single_chip = 1'b1;
            rom_invalid = 1'b0;
         end
         MODE_ROMINV: begin
            single_chip = 1'b0;
            rom_invalid = 1'b1;
         end
         default: begin
            single_chip = 1'b0;
            rom_invalid = 1'b0;
         end
      endcase
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         direction_ff <= RST_DIRECTION;
      end else if (req.wr && req.addr == OFS_DIRECTION && !hold_active) begin
         direction_ff <= req.wdata;
      end
   end

   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         function_ff <= RST_FUNCTION;
      end else if (req.wr && req.addr == OFS_FUNCTION && !hold_active) begin
         function_ff <= req.wdata;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < PIN_COUNT; gi++) begin : g_pin
         pin_function_cell u_cell (
            .dir_bit_i(direction_ff[gi]),
            .func_bit_i(function_ff[gi]),
            .single_chip_i(single_chip),
            .rom_invalid_i(rom_invalid),
            .port_data_i(PORT_DATA_I[gi]),
            .addr_line_i(ADDR_LINE_I[gi]),
            .drive_o(drive[gi])
         );
         assign nxt_pin_o[gi] = drive[gi].level;
         assign nxt_pin_oe[gi] = drive[gi].enable;
         assign nxt_addr_sel[gi] = drive[gi].is_addr;
      end
   endgenerate

   // Registered pin drive keeps outputs glitch free; costs one cycle of latency
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pin_o_ff <= 16'h0000;
         pin_oe_ff <= 16'h0000;
         addr_sel_ff <= 16'h0000;
      end else begin
         pin_o_ff <= nxt_pin_o;
         pin_oe_ff <= nxt_pin_oe;
         addr_sel_ff <= nxt_addr_sel;
      end
   end

   always_comb begin
      case (req.addr)
         OFS_DIRECTION: nxt_rdata = direction_ff;
         OFS_FUNCTION: nxt_rdata = function_ff;
         OFS_EFFECTIVE: nxt_rdata = addr_sel_ff;
         OFS_PIN_LEVEL: nxt_rdata = pin_sync;
         OFS_MODE: begin
            nxt_rdata = 16'h0000;
            nxt_rdata[MODE_SINGLE_BIT] = single_chip;
            nxt_rdata[MODE_ROMINV_BIT] = rom_invalid;
            nxt_rdata[MODE_HOLD_BIT] = hold_active;
         end
         default: nxt_rdata = READ_UNMAPPED;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rdata_ff <= 16'h0000;
      end else if (req.rd) begin
         rdata_ff <= nxt_rdata;
      end else begin
         rdata_ff <= 16'h0000;
      end
   end

   assign REG_RDATA_O = rdata_ff;
   assign PIN_O = pin_o_ff;
   assign PIN_OE_O = pin_oe_ff;
   assign PIN_LEVEL_O = pin_sync;
   assign ADDR_SELECT_O = addr_sel_ff;

endmodule : port_c_pin_function_direction

`default_nettype wire

// ===== src/portc_pkg.sv
/*
 * Constants and types shared by the port C pin function and direction block.
 * Assumes a single 100 MHz system clock and a simple strobe-based register port.
 */
`default_nettype none

package portc_pkg;

   localparam int PIN_COUNT = 16;
   localparam int ADDR_W = 4;
   localparam int DATA_W = 16;

   // Register indices on the register port
   localparam logic [3:0] OFS_DIRECTION = 4'h0;
   localparam logic [3:0] OFS_FUNCTION = 4'h1;
   localparam logic [3:0] OFS_EFFECTIVE = 4'h2;
   localparam logic [3:0] OFS_PIN_LEVEL = 4'h3;
   localparam logic [3:0] OFS_MODE = 4'h4;

   localparam logic [15:0] RST_DIRECTION = 16'h0000;
   localparam logic [15:0] RST_FUNCTION = 16'h0000;
   localparam logic [15:0] READ_UNMAPPED = 16'h0000;

   // Mode status fields
   localparam int MODE_SINGLE_BIT = 0;
   localparam int MODE_ROMINV_BIT = 1;
   localparam int MODE_HOLD_BIT = 2;

   // Strap capture waits for the two-stage synchroniser to fill
   localparam logic [1:0] STRAP_SETTLE = 2'd2;
   localparam logic [1:0] STRAP_DONE = 2'd3;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_ROMINV = 2'b10
   } chip_mode_t;

   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_t;

   typedef struct packed {
      logic level;
      logic enable;
      logic is_addr;
   } pin_drive_t;

endpackage : portc_pkg

`default_nettype wire

// ===== src/sync_two_stage.sv
/*
 * Two flip-flop synchroniser for a bundle of levels.
 * Assumes the inputs are asynchronous to CLK_SYS_I and only levels matter.
 */
`default_nettype none

module sync_two_stage #(
   parameter int WIDTH = 16
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] async_i,
   output logic [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_i;
         sync_ff <= meta_ff;
      end
   end

   assign sync_o = sync_ff;

endmodule : sync_two_stage

`default_nettype wire

// ===== src/pin_function_cell.sv
/*
 * Function and direction decision for one multiplexed port pin.
 * Assumes mode flags are already stable and registered by the caller.
 */
`default_nettype none

module pin_function_cell
   import portc_pkg::*;
(
   input wire logic dir_bit_i,
   input wire logic func_bit_i,
   input wire logic single_chip_i,
   input wire logic rom_invalid_i,
   input wire logic port_data_i,
   input wire logic addr_line_i,
   output pin_drive_t drive_o
);

   logic use_addr;

   always_comb begin
      if (single_chip_i) begin
         use_addr = 1'b0;
      end else if (rom_invalid_i) begin
         use_addr = 1'b1;
      end else begin
         use_addr = func_bit_i;
      end
   end

   always_comb begin
      drive_o.is_addr = use_addr;
      if (use_addr) begin
         drive_o.enable = 1'b1;
         drive_o.level = addr_line_i;
      end else begin
         drive_o.enable = dir_bit_i;
         drive_o.level = dir_bit_i & port_data_i;
      end
   end

endmodule : pin_function_cell

`default_nettype wire

// ===== tb/portc_pin_model.sv
/* Far-side pin model: resolves each shared pin from both drivers.
   Assumes no pull resistors; the outside device drives any pin the block leaves. */
`default_nettype none
module portc_pin_model (
   input wire logic [15:0] pin_o_i,
   input wire logic [15:0] pin_oe_i,
   input wire logic [15:0] ext_val_i,
   output logic [15:0] pin_i_o
);
   timeunit 1ns;
   timeprecision 1ns;
   assign pin_i_o = (pin_oe_i & pin_o_i) | (~pin_oe_i & ext_val_i);
endmodule : portc_pin_model
`default_nettype wire

// ===== tb/port_c_pin_function_direction_sva.sv
/* Port-level checks of the pin function block, bound to its top module.
   Assumes the mode straps stay stable while RST_N_I is high. */
`default_nettype none
module portc_pins_sva (
   input wire logic CLK_SYS_I,
   input wire logic RST_N_I,
   input wire logic [3:0] REG_ADDR_I,
   input wire logic REG_RD_I,
   input wire logic [15:0] REG_RDATA_O,
   input wire logic MODE_SINGLE_CHIP_I,
   input wire logic MODE_ROM_INVALID_I,
   input wire logic [15:0] PORT_DATA_I,
   input wire logic [15:0] ADDR_LINE_I,
   input wire logic [15:0] PIN_I,
   input wire logic [15:0] PIN_O,
   input wire logic [15:0] PIN_OE_O,
   input wire logic [15:0] PIN_LEVEL_O,
   input wire logic [15:0] ADDR_SELECT_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (!RST_N_I);
   a_addr_oe: assert property ((PIN_OE_O & ADDR_SELECT_O) == ADDR_SELECT_O)
      else $error("address pin not driven");
   a_addr_level: assert property (((PIN_O ^ $past(ADDR_LINE_I)) & ADDR_SELECT_O) == 0)
      else $error("address pin level wrong");
   a_gp_data: assert property (((PIN_O ^ $past(PORT_DATA_I)) & PIN_OE_O & ~ADDR_SELECT_O) == 0)
      else $error("output pin data wrong");
   a_input_quiet: assert property ((PIN_O & ~PIN_OE_O) == 16'h0000)
      else $error("input pin shows level");
   a_single_gp: assert property (MODE_SINGLE_CHIP_I |-> ADDR_SELECT_O == 16'h0000)
      else $error("address function in single chip");
   a_rominv_addr: assert property (MODE_ROM_INVALID_I && !MODE_SINGLE_CHIP_I
      && $past(RST_N_I, 4) |-> ADDR_SELECT_O == 16'hffff) else $error("rom invalid not forced");
   a_rd_quiet: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
      else $error("read data outside slot");
   a_unmapped_rd: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) > 4'h4
      |-> REG_RDATA_O == 16'h0000) else $error("unmapped read not zero");
   a_level_sync: assert property ($past(RST_N_I, 2) |-> PIN_LEVEL_O == $past(PIN_I, 2))
      else $error("pin level lag wrong");
   c_rominv: cover property (ADDR_SELECT_O == 16'hffff);
   c_read: cover property ($past(REG_RD_I) && REG_RDATA_O != 16'h0000);
   c_out: cover property ((PIN_OE_O & ~ADDR_SELECT_O) != 16'h0000);
endmodule : portc_pins_sva
bind port_c_pin_function_direction portc_pins_sva chk (.*);
`default_nettype wire

// ===== tb/port_c_pin_function_direction_tb_top.sv
/* Self-checking bench for the pin function block with a far-side pin model.
   Assumes the hand-over timing: read data one cycle after the strobe. */
`default_nettype none
module port_c_pin_function_direction_tb_top
   import portc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst_n, wr, rd, rd_d, single, rominv, man_n, wdt, stby, slp;
   logic [3:0] addr;
   logic [15:0] wdata, pd, al, ext, rdata, pin_i, pin_o, oe, lvl, asel;
   logic [15:0] d, f, p, a, x, ox, px, e;
   logic [15:0] exp_q[$];
   int err_total, checks, seed;
   port_c_pin_function_direction uut (.CLK_SYS_I(clk), .RST_N_I(rst_n), .REG_ADDR_I(addr),
      .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
      .MODE_SINGLE_CHIP_I(single), .MODE_ROM_INVALID_I(rominv), .MANUAL_RST_N_I(man_n),
      .WDT_RST_I(wdt), .STANDBY_I(stby), .SLEEP_I(slp), .PORT_DATA_I(pd), .ADDR_LINE_I(al),
      .PIN_I(pin_i), .PIN_O(pin_o), .PIN_OE_O(oe), .PIN_LEVEL_O(lvl), .ADDR_SELECT_O(asel));
   portc_pin_model far (.pin_o_i(pin_o), .pin_oe_i(oe), .ext_val_i(ext), .pin_i_o(pin_i));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wrap_up();
      if (err_total == 0 && checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   task automatic wreg(input logic [3:0] ad, input logic [15:0] dt);
      @(posedge clk);
      wr <= 1'b1;
      addr <= ad;
      wdata <= dt;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] ad, input logic [15:0] ex);
      @(posedge clk);
      rd <= 1'b1;
      addr <= ad;
      exp_q.push_back(ex);
      @(posedge clk);
      rd <= 1'b0;
   endtask : rreg
   task automatic por(input logic s, input logic r);
      @(posedge clk);
      single <= s;
      rominv <= r;
      rst_n <= 1'b0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
   endtask : por
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) rd_d <= rd;
   always @(negedge clk) if (rd_d) chk(rdata, exp_q.pop_front());
   initial begin
      #200000;
      err_total++;
      wrap_up();
   end
   initial begin
      seed = 32'hb49c0f32;
      {wr, rd, single, rominv, wdt, stby, slp} = '0;
      {man_n, rst_n, addr, wdata, pd, al, ext} = '0;
      man_n = 1'b1;
      por(1'b0, 1'b0);
      rreg(OFS_DIRECTION, RST_DIRECTION);
      rreg(OFS_FUNCTION, RST_FUNCTION);
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         d = 16'($random(seed));
         f = 16'($random(seed));
         p = 16'($random(seed));
         a = 16'($random(seed));
         x = 16'($random(seed));
         pd <= p;
         al <= a;
         ext <= x;
         ox = d | f;
         px = (d & ~f & p) | (f & a);
         wreg(OFS_DIRECTION, d);
         wreg(OFS_FUNCTION, f);
         // Unmapped index must leave both registers alone
         wreg(4'h9, 16'hffff);
         rreg(OFS_DIRECTION, d);
         rreg(OFS_FUNCTION, f);
         rreg(4'h9, READ_UNMAPPED);
         rreg(OFS_EFFECTIVE, f);
         rreg(OFS_PIN_LEVEL, (ox & px) | (~ox & x));
         #1;
         chk(oe, ox);
         chk(pin_o, px);
         chk(asel, f);
      end
      for (int k = 0; k < 4; k++) begin
         @(posedge clk);
         {man_n, wdt, stby, slp} <= 4'b1000 ^ (4'b1000 >> k);
         repeat (4) @(posedge clk);
         // Writes while held must not land
         wreg(OFS_DIRECTION, ~d);
         wreg(OFS_FUNCTION, ~f);
         rreg(OFS_MODE, 16'h0001 << MODE_HOLD_BIT);
         rreg(OFS_DIRECTION, d);
         rreg(OFS_FUNCTION, f);
         {man_n, wdt, stby, slp} <= 4'b1000;
         repeat (3) @(posedge clk);
         #1;
         chk(oe, ox);
      end
      // Mode 3 has both straps high: single chip must win
      for (int m = 1; m < 4; m++) begin
         por(m[0], m[1]);
         rreg(OFS_DIRECTION, RST_DIRECTION);
         rreg(OFS_FUNCTION, RST_FUNCTION);
         wreg(OFS_FUNCTION, m[0] ? 16'hffff : 16'h0000);
         wreg(OFS_DIRECTION, 16'h00ff);
         rreg(OFS_MODE, (16'(m[0]) << MODE_SINGLE_BIT) | (16'(m == 2) << MODE_ROMINV_BIT));
         e = (m == 2) ? 16'hffff : 16'h0000;
         repeat (3) @(posedge clk);
         #1;
         chk(asel, e);
         chk(oe, e | 16'h00ff);
         chk(pin_o, (~e & 16'h00ff & pd) | (e & al));
      end
      wrap_up();
   end
endmodule : port_c_pin_function_direction_tb_top
`default_nettype wire
